// File: gss_pkg.sv
// Package for the genset start/stop sequencer: register map, fields, states, timing.
// Assumes a 50 MHz system clock and AXI4-Lite access with 32-bit data.
package gss_pkg;
   // ----------------------------------------
   // Clock and time units
   // ----------------------------------------
   localparam int unsigned CLK_HZ = 50000000;
   localparam int unsigned TICK_MS = 1;
   localparam int unsigned TICK_CYC = CLK_HZ / 1000 * TICK_MS;
   localparam int unsigned PUMP_DELAY_MS = 2000;
   localparam int unsigned PUMP_DELAY_TICKS = PUMP_DELAY_MS / TICK_MS;
   // ----------------------------------------
   // Register offsets
   // ----------------------------------------
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_START_DLY = 8'h08;
   localparam logic [7:0] REG_CRANK = 8'h0c;
   localparam logic [7:0] REG_REST = 8'h10;
   localparam logic [7:0] REG_SAFETY = 8'h14;
   localparam logic [7:0] REG_WARM = 8'h18;
   localparam logic [7:0] REG_RETURN = 8'h1c;
   localparam logic [7:0] REG_COOL = 8'h20;
   localparam logic [7:0] REG_SPEED = 8'h24;
   localparam logic [7:0] REG_ID = 8'h28;
   // Arbitrary neutral identity value
   localparam logic [31:0] GSS_ID_VAL = 32'h0000_5e01;
   // ----------------------------------------
   // Control fields
   // ----------------------------------------
   localparam int CTL_ATTEMPTS_LSB = 0;
   localparam int CTL_ATTEMPTS_W = 4;
   localparam int CTL_WARM_EN = 4;
   localparam int CTL_MPU_EN = 5;
   localparam int CTL_OILREL_EN = 6;
   localparam int CTL_CAN_EN = 7;
   localparam int CTL_PUMP_EN = 8;
   localparam int CTL_SPEED_EN = 9;
   localparam logic [31:0] CTRL_RST = 32'h0000_0013;
   localparam logic [31:0] START_DLY_RST = 32'h0000_1388;
   localparam logic [31:0] CRANK_RST = 32'h0000_2710;
   localparam logic [31:0] REST_RST = 32'h0000_2710;
   localparam logic [31:0] SAFETY_RST = 32'h0000_2710;
   localparam logic [31:0] WARM_RST = 32'h0000_0bb8;
   localparam logic [31:0] RETURN_RST = 32'h0000_7530;
   localparam logic [31:0] COOL_RST = 32'h0001_d4c0;
   localparam logic [15:0] SPEED_RST = 16'h05dc;
   localparam logic [15:0] SPEED_STEP = 16'h000a;
   localparam logic [1:0] AXI_OKAY = 2'b00;
   localparam logic [1:0] AXI_SLVERR = 2'b10;
   // ----------------------------------------
   // Sequencer states and modes
   // ----------------------------------------
   typedef enum logic [3:0] {
      GSS_ST_STANDBY, GSS_ST_START_DLY, GSS_ST_CRANK, GSS_ST_REST,
      GSS_ST_RUN, GSS_ST_RETURN, GSS_ST_COOL, GSS_ST_FAIL
   } gss_state_t;
   typedef enum logic [1:0] {
      GSS_MODE_STOP, GSS_MODE_MANUAL, GSS_MODE_AUTO
   } gss_mode_t;
endpackage

// File: gss_sequencer.sv
// Genset start/stop sequencer with AXI4-Lite configuration and status registers.
// Assumes all panel, engine and CAN inputs are synchronous, debounced levels.
//
// Functional notes
// - Panel lock input blocks mode changes; status reads stay available.
// - Auto start request: utility fail, remote start or scheduler.
// - Auto start runs a start delay timer first.
// - Requests gone before start delay ends returns to standby.
// - Request still present at delay end: fuel on, crank.
// - No fire during crank: starter off for rest, then retry.
// - Attempts exhausted: stop sequence, raise fail-to-start.
// - Starter released on firing: alternator or magnetic pickup.
// - Oil pressure optionally releases starter; never speed faults.
// - Safety-on timer after starter release masks listed faults.
// - Optional warm-up timer before load transfer.
// - Load output stays off until oil pressure has risen.
// - Auto running, requests gone: start return delay if loaded, else cooling.
// - New request during return or cooling puts set back on load.
// - Return delay ends: load to utility, cooling starts off load.
// - Cooling ends: fuel de-energised.
// - Manual: no auto start; start button cranks immediately.
// - Manual running: load only on a loading request source.
// - Manual loaded: unload by utility, open button or auto.
// - Fuel pump energised after two seconds held; off on release.
// - Speed edit mode; up/down change setpoint, kept on exit.
// - Electronic engine: CAN start command and CAN firing input.
`timescale 1ns/10ps
`default_nettype none
module gss_sequencer
   import gss_pkg::*;
#(
   parameter int unsigned TICK_CYCLES = TICK_CYC
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Panel buttons and inputs
   input wire logic panel_lock,
   input wire logic btn_stop,
   input wire logic btn_manual,
   input wire logic btn_auto,
   input wire logic btn_start,
   input wire logic btn_to_gen,
   input wire logic btn_to_util,
   input wire logic btn_open_gen,
   input wire logic btn_pump,
   input wire logic btn_edit,
   input wire logic btn_up,
   input wire logic btn_down,
   // Start and load request sources
   input wire logic utility_fail,
   input wire logic remote_start,
   input wire logic remote_start_load,
   input wire logic sched_run,
   input wire logic sched_on_load,
   // Engine sensing
   input wire logic alt_fired,
   input wire logic mpu_fired,
   input wire logic can_fired,
   input wire logic oil_risen,
   // Outputs to engine and switchgear
   output logic fuel_on,
   output logic starter_on,
   output logic load_gen,
   output logic can_start,
   output logic pump_on,
   output logic safety_on,
   output logic fail_start,
   output logic [15:0] speed_set
);
   // ----------------------------------------
   // Configuration registers
   // ----------------------------------------
   logic [31:0] ctrl_r, start_dly_r, crank_r, rest_r, safety_r, warm_r, ret_r, cool_r;
   logic [15:0] speed_r;
   gss_state_t state_r;
   gss_mode_t mode_r;
   logic [31:0] tmr_r, safe_tmr_r, warm_tmr_r;
   logic [CTL_ATTEMPTS_W-1:0] att_r;
   logic tick_r, loaded_r, edit_r, up_q_r, dn_q_r, edit_q_r;
   logic [$clog2(TICK_CYCLES+1)-1:0] div_r;
   logic [15:0] pump_cnt_r;

   // ----------------------------------------
   // AXI4-Lite slave
   // ----------------------------------------
   logic [7:0] awaddr_r;
   logic [31:0] wdata_r;
   logic [3:0] wstrb_r;
   logic aw_got_r, w_got_r;
   logic do_wr;
   assign do_wr = aw_got_r && w_got_r && !s_axi_bvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_got_r <= 1'b0;
         w_got_r <= 1'b0;
         awaddr_r <= 8'h00;
         wdata_r <= 32'h0000_0000;
         wstrb_r <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= AXI_OKAY;
      end else begin
         s_axi_awready <= !aw_got_r && !s_axi_awready && s_axi_awvalid;
         s_axi_wready <= !w_got_r && !s_axi_wready && s_axi_wvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_got_r <= 1'b1;
            awaddr_r <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_got_r <= 1'b1;
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
         end
         if (do_wr) begin
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (awaddr_r > REG_SPEED || awaddr_r[1:0] != 2'b00) ? AXI_SLVERR
                                                                             : AXI_OKAY;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] be);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) res[i*8 +: 8] = nw[i*8 +: 8];
      end
      return res;
   endfunction

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_r <= CTRL_RST;
         start_dly_r <= START_DLY_RST;
         crank_r <= CRANK_RST;
         rest_r <= REST_RST;
         safety_r <= SAFETY_RST;
         warm_r <= WARM_RST;
         ret_r <= RETURN_RST;
         cool_r <= COOL_RST;
      end else if (do_wr) begin
         case (awaddr_r)
            REG_CTRL: ctrl_r <= merge(ctrl_r, wdata_r, wstrb_r);
            REG_START_DLY: start_dly_r <= merge(start_dly_r, wdata_r, wstrb_r);
            REG_CRANK: crank_r <= merge(crank_r, wdata_r, wstrb_r);
            REG_REST: rest_r <= merge(rest_r, wdata_r, wstrb_r);
            REG_SAFETY: safety_r <= merge(safety_r, wdata_r, wstrb_r);
            REG_WARM: warm_r <= merge(warm_r, wdata_r, wstrb_r);
            REG_RETURN: ret_r <= merge(ret_r, wdata_r, wstrb_r);
            REG_COOL: cool_r <= merge(cool_r, wdata_r, wstrb_r);
            default: ;
         endcase
      end
   end

   // Read channel: one-cycle registered answer
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= AXI_OKAY;
      end else begin
         s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= AXI_OKAY;
            case (s_axi_araddr)
               REG_CTRL: s_axi_rdata <= ctrl_r;
               REG_STATUS: s_axi_rdata <= {20'h0_0000, att_r, edit_r, loaded_r,
                                           mode_r, 4'(state_r)};
               REG_START_DLY: s_axi_rdata <= start_dly_r;
               REG_CRANK: s_axi_rdata <= crank_r;
               REG_REST: s_axi_rdata <= rest_r;
               REG_SAFETY: s_axi_rdata <= safety_r;
               REG_WARM: s_axi_rdata <= warm_r;
               REG_RETURN: s_axi_rdata <= ret_r;
               REG_COOL: s_axi_rdata <= cool_r;
               REG_SPEED: s_axi_rdata <= {16'h0000, speed_r};
               REG_ID: s_axi_rdata <= GSS_ID_VAL;
               default: begin
                  s_axi_rdata <= 32'h0000_0000;
                  s_axi_rresp <= AXI_SLVERR;
               end
            endcase
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // Timebase
   // ----------------------------------------
   // Millisecond tick from system clock
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         div_r <= '0;
         tick_r <= 1'b0;
      end else if (div_r == $bits(div_r)'(TICK_CYCLES - 1)) begin
         div_r <= '0;
         tick_r <= 1'b1;
      end else begin
         div_r <= div_r + 1'b1;
         tick_r <= 1'b0;
      end
   end

   // ----------------------------------------
   // Mode selection
   // ----------------------------------------
   // Lock freezes mode
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mode_r <= GSS_MODE_STOP;
      end else if (!panel_lock) begin
         if (btn_stop) mode_r <= GSS_MODE_STOP;
         else if (btn_auto) mode_r <= GSS_MODE_AUTO;
         else if (btn_manual) mode_r <= GSS_MODE_MANUAL;
      end
   end

   // ----------------------------------------
   // Start/stop sequencer
   // ----------------------------------------
   logic auto_req, fired, is_auto, load_req;
   assign is_auto = (mode_r == GSS_MODE_AUTO);
   assign auto_req = is_auto && (utility_fail || remote_start || sched_run);
   assign fired = (ctrl_r[CTL_CAN_EN] ? can_fired
                   : (ctrl_r[CTL_MPU_EN] ? mpu_fired : alt_fired))
                  || (ctrl_r[CTL_OILREL_EN] && oil_risen);
   assign load_req = btn_to_gen || utility_fail || remote_start_load
                     || (sched_run && sched_on_load);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_r <= GSS_ST_STANDBY;
         tmr_r <= 32'h0000_0000;
         att_r <= '0;
      end else begin
         if (tick_r && tmr_r != 32'h0000_0000) tmr_r <= tmr_r - 1'b1;
         case (state_r)
            GSS_ST_STANDBY: begin
               att_r <= '0;
               if (auto_req) begin
                  state_r <= GSS_ST_START_DLY;
                  tmr_r <= start_dly_r;
               end else if (mode_r == GSS_MODE_MANUAL && btn_start) begin
                  state_r <= GSS_ST_CRANK;
                  tmr_r <= crank_r;
                  att_r <= CTL_ATTEMPTS_W'(1);
               end
            end
            GSS_ST_START_DLY: begin
               if (!auto_req) state_r <= GSS_ST_STANDBY;
               else if (tmr_r == 32'h0000_0000) begin
                  state_r <= GSS_ST_CRANK;
                  tmr_r <= crank_r;
                  att_r <= CTL_ATTEMPTS_W'(1);
               end
            end
            GSS_ST_CRANK: begin
               if (fired) begin
                  state_r <= GSS_ST_RUN;
               end else if (tmr_r == 32'h0000_0000) begin
                  if (att_r >= ctrl_r[CTL_ATTEMPTS_LSB +: CTL_ATTEMPTS_W]) begin
                     state_r <= GSS_ST_FAIL;
                  end else begin
                     state_r <= GSS_ST_REST;
                     tmr_r <= rest_r;
                  end
               end
            end
            GSS_ST_REST: begin
               if (tmr_r == 32'h0000_0000) begin
                  state_r <= GSS_ST_CRANK;
                  tmr_r <= crank_r;
                  att_r <= att_r + 1'b1;
               end
            end
            GSS_ST_RUN: begin
               if (is_auto && !auto_req && !loaded_r) begin
                  state_r <= GSS_ST_COOL;
                  tmr_r <= cool_r;
               end else if (is_auto && !auto_req) begin
                  state_r <= GSS_ST_RETURN;
                  tmr_r <= ret_r;
               end
            end
            GSS_ST_RETURN: begin
               if (auto_req) state_r <= GSS_ST_RUN;
               else if (tmr_r == 32'h0000_0000) begin
                  state_r <= GSS_ST_COOL;
                  tmr_r <= cool_r;
               end
            end
            GSS_ST_COOL: begin
               if (auto_req) state_r <= GSS_ST_RUN;
               else if (tmr_r == 32'h0000_0000) state_r <= GSS_ST_STANDBY;
            end
            GSS_ST_FAIL: begin
               if (mode_r == GSS_MODE_STOP) state_r <= GSS_ST_STANDBY;
            end
            default: state_r <= GSS_ST_STANDBY;
         endcase
         // Stop mode ends any run at once
         if (mode_r == GSS_MODE_STOP && state_r != GSS_ST_FAIL) state_r <= GSS_ST_STANDBY;
      end
   end

   // ----------------------------------------
   // Safety-on and warm-up timers
   // ----------------------------------------
   logic running;
   assign running = (state_r == GSS_ST_RUN) || (state_r == GSS_ST_RETURN)
                    || (state_r == GSS_ST_COOL);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         safe_tmr_r <= 32'h0000_0000;
         safety_on <= 1'b0;
      end else begin
         if (state_r == GSS_ST_CRANK && fired) safe_tmr_r <= safety_r;
         else if (tick_r && safe_tmr_r != 32'h0000_0000) safe_tmr_r <= safe_tmr_r - 1'b1;
         safety_on <= running && safe_tmr_r == 32'h0000_0000;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         warm_tmr_r <= 32'h0000_0000;
      end else if (state_r == GSS_ST_CRANK && fired) begin
         warm_tmr_r <= ctrl_r[CTL_WARM_EN] ? warm_r : 32'h0000_0000;
      end else if (tick_r && warm_tmr_r != 32'h0000_0000) begin
         warm_tmr_r <= warm_tmr_r - 1'b1;
      end
   end

   // ----------------------------------------
   // Load transfer
   // ----------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         loaded_r <= 1'b0;
      end else if (!running || mode_r == GSS_MODE_STOP) begin
         loaded_r <= 1'b0;
      end else if (is_auto) begin
         loaded_r <= (state_r != GSS_ST_COOL) && warm_tmr_r == 32'h0000_0000
                     && !(state_r == GSS_ST_RETURN && tmr_r == 32'h0000_0000);
      end else if (btn_to_util || btn_open_gen) begin
         loaded_r <= 1'b0;
      end else if (load_req && warm_tmr_r == 32'h0000_0000) begin
         loaded_r <= 1'b1;
      end
   end

   // ----------------------------------------
   // Engine outputs
   // ----------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         fuel_on <= 1'b0;
         starter_on <= 1'b0;
         load_gen <= 1'b0;
         can_start <= 1'b0;
         fail_start <= 1'b0;
      end else begin
         fuel_on <= (state_r == GSS_ST_CRANK) || (state_r == GSS_ST_REST) || running;
         starter_on <= (state_r == GSS_ST_CRANK) && !fired;
         load_gen <= loaded_r && oil_risen;
         can_start <= ctrl_r[CTL_CAN_EN] && (state_r == GSS_ST_CRANK || running);
         fail_start <= (state_r == GSS_ST_FAIL);
      end
   end

   // ----------------------------------------
   // Manual fuel pump and speed edit
   // ----------------------------------------
   // Pump after hold delay
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pump_cnt_r <= 16'h0000;
         pump_on <= 1'b0;
      end else if (!btn_pump || !ctrl_r[CTL_PUMP_EN]) begin
         pump_cnt_r <= 16'h0000;
         pump_on <= 1'b0;
      end else if (pump_cnt_r == 16'(PUMP_DELAY_TICKS)) begin
         pump_on <= 1'b1;
      end else if (tick_r) begin
         pump_cnt_r <= pump_cnt_r + 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         edit_r <= 1'b0;
         speed_r <= SPEED_RST;
         up_q_r <= 1'b0;
         dn_q_r <= 1'b0;
         edit_q_r <= 1'b0;
         speed_set <= SPEED_RST;
      end else begin
         up_q_r <= btn_up;
         dn_q_r <= btn_down;
         edit_q_r <= btn_edit;
         if (btn_edit && !edit_q_r && ctrl_r[CTL_SPEED_EN]) edit_r <= !edit_r;
         if (edit_r && btn_up && !up_q_r) speed_r <= speed_r + SPEED_STEP;
         else if (edit_r && btn_down && !dn_q_r && speed_r >= SPEED_STEP)
            speed_r <= speed_r - SPEED_STEP;
         speed_set <= speed_r;
      end
   end
endmodule
`default_nettype wire

// File: gss_asserts.sv
// Checker for the sequencer outputs against their causes.
// Assumes it is bound to gss_sequencer, one clock domain.
`timescale 1ns/10ps
`default_nettype none
module gss_asserts (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Inputs seen
   input wire logic btn_pump,
   input wire logic alt_fired,
   input wire logic mpu_fired,
   input wire logic oil_risen,
   // Outputs watched
   input wire logic fuel_on,
   input wire logic starter_on,
   input wire logic load_gen,
   input wire logic pump_on,
   input wire logic safety_on,
   input wire logic fail_start
);
   logic oil_seen_r;
   default clocking @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   // Load may lag the sensor, so keep its history
   always_ff @(posedge aclk) begin
      if (!aresetn)
         oil_seen_r <= 1'b0;
      else if (oil_risen)
         oil_seen_r <= 1'b1;
   end
   fuel_crank_a: assert property (starter_on |-> fuel_on)
      else $error("starter without fuel");
   load_oil_a: assert property (load_gen |-> oil_seen_r)
      else $error("load before oil");
   fail_quiet_a: assert property (fail_start |-> !starter_on && !load_gen)
      else $error("active after fail");
   fire_release_a: assert property (starter_on && alt_fired && mpu_fired |-> ##[1:3] !starter_on)
      else $error("starter held after firing");
   safety_mask_a: assert property ($fell(starter_on) |-> !safety_on [*2])
      else $error("faults armed early");
   pump_delay_a: assert property ($rose(btn_pump) |-> !pump_on [*8])
      else $error("pump too early");
   pump_off_a: assert property (!btn_pump |-> ##2 !pump_on)
      else $error("pump left on");
   load_run_a: assert property ($rose(load_gen) |-> !starter_on)
      else $error("load while cranking");
   load_fuel_a: assert property (load_gen |-> fuel_on)
      else $error("load with engine stopped");
   cover property ($rose(load_gen));
   cover property ($rose(fail_start));
   cover property ($rose(pump_on));
endmodule
bind gss_sequencer gss_asserts i_chk (.*);
`default_nettype wire

// File: gss_engine_model.sv
// Engine model: fires after three starter cycles, oil follows.
// Assumes the sequencer clock; dead keeps it from firing.
`timescale 1ns/10ps
`default_nettype none
module gss_engine_model (
   // Clock and fault
   input wire logic aclk,
   input wire logic dead,
   // From the sequencer
   input wire logic fuel_on,
   input wire logic starter_on,
   // Sense lines
   output logic alt_fired,
   output logic mpu_fired,
   output logic oil_risen
);
   logic [2:0] spin_r;
   logic [2:0] oil_r;
   // No fuel, no combustion: speed is lost at once
   always_ff @(posedge aclk) begin
      if (!fuel_on || dead)
         spin_r <= 3'h0;
      else if (starter_on && spin_r < 3'h3)
         spin_r <= spin_r + 3'h1;
   end
   always_ff @(posedge aclk) begin
      if (!alt_fired)
         oil_r <= 3'h0;
      else if (oil_r < 3'h4)
         oil_r <= oil_r + 3'h1;
   end
   assign alt_fired = (spin_r == 3'h3);
   assign mpu_fired = alt_fired;
   assign oil_risen = (oil_r == 3'h4);
endmodule
`default_nettype wire

// File: test_genset_start_stop_sequencer.sv
// Self-checking bench for the genset sequencer with an engine model.
// Assumes gss_pkg, the engine model and the bound checker are compiled first.
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin n_errors++; \
   $display("MISMATCH %s exp %h got %h", nm, e, g); end end
`define WAITF(c, n, nm) begin @(negedge aclk); for (wk = 0; wk < n && !(c); wk++) \
   @(negedge aclk); `CHK(nm, 1'b1, c) if (!(c)) end_of_test(); end
module test_genset_start_stop_sequencer
   import gss_pkg::*;
;
   logic aclk = '0, aresetn = '0, s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0;
   logic s_axi_arvalid = '0, s_axi_rready = '0, panel_lock = '0, btn_stop = '0;
   logic btn_manual = '0, btn_auto = '0, btn_start = '0, btn_to_gen = '0, btn_to_util = '0;
   logic btn_open_gen = '0, btn_pump = '0, btn_edit = '0, btn_up = '0, btn_down = '0;
   logic dead = '0, can_fired = '0, utility_fail = '0, remote_start = '0;
   logic remote_start_load = '0, sched_run = '0, sched_on_load = '0;
   logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
   logic [31:0] s_axi_wdata = '0, s_axi_rdata, sd;
   logic [3:0] s_axi_wstrb = '0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic fuel_on, starter_on, load_gen, can_start, pump_on, safety_on, fail_start;
   logic alt_fired, mpu_fired, oil_risen;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [15:0] speed_set;
   logic [31:0] tv [7];
   logic [2:0] ed [5] = '{3'h4, 3'h2, 3'h2, 3'h1, 3'h4};
   logic [33:0] exp_q [$], msk_q [$];
   int n_errors = 0, cmp_count = 0, wk, i;
   gss_sequencer #(.TICK_CYCLES(2)) i_dut (.*);
   gss_engine_model i_eng (.*);
   always #10 aclk = ~aclk;
   task automatic step(input int n);
      repeat (n) @(posedge aclk);
   endtask
   task automatic end_of_test;
      $display("comparisons %0d errors %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      logic [2:0] s = '0;
      step(1);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= 4'hf;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
      for (int k = 0; k < 50 && !s[0]; k++) begin
         @(negedge aclk);
         s = {s_axi_awready, s_axi_wready, s_axi_bvalid};
         @(posedge aclk);
         if (s[2]) s_axi_awvalid <= 1'b0;
         if (s[1]) s_axi_wvalid <= 1'b0;
      end
      s_axi_bready <= 1'b0;
      `CHK("bresp", {1'b1, er}, {s[0], s_axi_bresp})
      if (!s[0]) end_of_test();
   endtask
   // Expected read data is queued here and compared by the monitor
   task automatic axi_rd(input logic [7:0] a, input logic [33:0] e, input logic [33:0] m);
      logic [1:0] s = '0;
      step(1);
      exp_q.push_back(e);
      msk_q.push_back(m);
      s_axi_araddr <= a;
      {s_axi_arvalid, s_axi_rready} <= 2'h3;
      for (int k = 0; k < 50 && !s[0]; k++) begin
         @(negedge aclk);
         s = {s_axi_arready, s_axi_rvalid};
         @(posedge aclk);
         if (s[1]) s_axi_arvalid <= 1'b0;
      end
      s_axi_rready <= 1'b0;
      `CHK("rvalid", 1'b1, s[0])
      if (!s[0]) end_of_test();
   endtask
   always @(posedge aclk) begin
      if (s_axi_rvalid && s_axi_rready && exp_q.size() > 0) begin
         `CHK("rdata", exp_q[0] & msk_q[0], {s_axi_rresp, s_axi_rdata} & msk_q[0])
         void'(exp_q.pop_front());
         void'(msk_q.pop_front());
      end
   end
   initial begin
      #1500000;
      n_errors++;
      end_of_test();
   end
   initial begin
      void'($urandom(10));
      sd = 32'h2 + ($urandom % 4);
      tv = '{sd, 32'h4, 32'h2, 32'h3, 32'h2, 32'h3, 32'h3};
      step(6);
      aresetn <= 1'b1;
      axi_rd(REG_CTRL, {AXI_OKAY, CTRL_RST}, '1);
      axi_rd(8'h3c, {AXI_SLVERR, 32'h0}, '1);
      axi_wr(8'h3c, 32'h0, AXI_SLVERR);
      for (i = 0; i < 7; i++) axi_wr(REG_START_DLY + 8'(4 * i), tv[i], AXI_OKAY);
      axi_wr(REG_CTRL, 32'h0000_0312, AXI_OKAY);
      step(1);
      {panel_lock, btn_auto} <= 2'h3;
      step(1);
      {panel_lock, btn_auto} <= 2'h0;
      axi_rd(REG_STATUS, 34'h0, 34'h30);
      step(1);
      btn_auto <= 1'b1;
      step(1);
      btn_auto <= 1'b0;
      axi_rd(REG_STATUS, 34'h20, 34'h30);
      step(1);
      utility_fail <= 1'b1;
      step(1);
      utility_fail <= 1'b0;
      repeat (4 * sd + 8) @(negedge aclk);
      `CHK("idle", 1'b0, starter_on)
      `CHK("fuel", 1'b0, fuel_on)
      for (i = 0; i < 3; i++) begin
         step(1);
         {sched_run, remote_start, utility_fail} <= 3'(1 << i);
         step(2);
         @(negedge aclk);
         `CHK("early", 1'b0, fuel_on)
         `CHK("armed", 1'b0, safety_on)
         `WAITF(starter_on, 40, "crank")
         `WAITF(safety_on, 100, "safety")
         `WAITF(load_gen, 100, "load")
         step(1);
         {sched_run, remote_start, utility_fail} <= 3'h0;
         `WAITF(!load_gen, 100, "unload")
         if (i == 1) begin
            step(1);
            remote_start <= 1'b1;
            `WAITF(load_gen, 100, "reload")
            step(1);
            remote_start <= 1'b0;
            `WAITF(!load_gen, 100, "unload2")
         end
         `WAITF(!fuel_on, 100, "stop")
      end
      step(1);
      {dead, remote_start} <= 2'h3;
      `WAITF(fail_start, 400, "fail")
      step(1);
      {dead, remote_start, btn_stop} <= 3'h1;
      step(1);
      btn_stop <= 1'b0;
      `WAITF(!fail_start, 10, "clear")
      step(1);
      btn_manual <= 1'b1;
      step(1);
      {btn_manual, btn_start} <= 2'h1;
      `WAITF(starter_on, 4, "mstart")
      `WAITF(!starter_on, 20, "fired")
      step(1);
      btn_start <= 1'b0;
      repeat (60) @(negedge aclk);
      `CHK("mload", 1'b0, load_gen)
      `CHK("can", 1'b0, can_start)
      step(1);
      btn_to_gen <= 1'b1;
      step(1);
      btn_to_gen <= 1'b0;
      `WAITF(load_gen, 20, "gen")
      step(1);
      btn_open_gen <= 1'b1;
      step(1);
      btn_open_gen <= 1'b0;
      `WAITF(!load_gen, 10, "open")
      for (i = 0; i < 5; i++) begin
         step(2);
         {btn_edit, btn_up, btn_down} <= ed[i];
         step(1);
         {btn_edit, btn_up, btn_down} <= 3'h0;
      end
      repeat (4) @(negedge aclk);
      `CHK("speed", SPEED_RST + SPEED_STEP, speed_set)
      step(1);
      btn_pump <= 1'b1;
      step(2 * PUMP_DELAY_TICKS - 8);
      `CHK("pump0", 1'b0, pump_on)
      `WAITF(pump_on, 16, "pump")
      step(1);
      btn_pump <= 1'b0;
      `WAITF(!pump_on, 3, "pumpoff")
      end_of_test();
   end
endmodule
`default_nettype wire
